// ==== common/ptc_pkg.sv ====
// package: constants of the period timers
package ptc_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses on the register port)
  // ---------------------------------------------------------------
  localparam logic [7:0] PTC_OFS_CONTROL = 8'h10; // mode and run bits
  localparam logic [7:0] PTC_OFS_FIRST_COUNT = 8'h11; // first timer count
  localparam logic [7:0] PTC_OFS_SECOND_COUNT = 8'h12; // second timer count
  localparam logic [7:0] PTC_OFS_THIRD_LOW = 8'h13; // third timer count, low byte
  localparam logic [7:0] PTC_OFS_THIRD_HIGH = 8'h14; // third timer count, high byte
  localparam logic [7:0] PTC_OFS_EVENT_FLAGS = 8'h16; // peripheral_event_flags
  localparam logic [7:0] PTC_OFS_EVENT_ENABLES = 8'h17; // peripheral_event_enables
  localparam logic [7:0] PTC_OFS_FIRST_PERIOD = 8'h18; // first_period_limit
  localparam logic [7:0] PTC_OFS_SECOND_PERIOD = 8'h19; // second_period_limit
  localparam logic [7:0] PTC_OFS_THIRD_PER_LOW = 8'h1A; // third period / capture, low
  localparam logic [7:0] PTC_OFS_THIRD_PER_HIGH = 8'h1B; // third period / capture, high

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PTC_RST_FLAGS = 8'h02;
  localparam logic [7:0] PTC_RST_ENABLES = 8'h00;
  localparam logic [7:0] PTC_RST_CONTROL = 8'h00;
  localparam logic [7:0] PTC_RST_PERIOD = 8'hFF;
  localparam logic [7:0] PTC_RD_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // bit positions: event flag / enable registers
  // ---------------------------------------------------------------
  localparam int PTC_BIT_FIRST_FLAG = 4;
  localparam int PTC_BIT_SECOND_FLAG = 5;
  localparam int PTC_BIT_THIRD_FLAG = 6;

  // ---------------------------------------------------------------
  // bit positions: control register
  // ---------------------------------------------------------------
  localparam int PTC_BIT_FIRST_EXT = 0; // first timer counts shared pin edges
  localparam int PTC_BIT_SECOND_EXT = 1; // second timer counts shared pin edges
  localparam int PTC_BIT_THIRD_EXT = 2; // third timer counts its own pin edges
  localparam int PTC_BIT_JOINED = 3; // first and second joined into 16 bits
  localparam int PTC_BIT_DUAL_CAPTURE = 4; // third period register becomes capture
  localparam int PTC_BIT_FIRST_RUN = 5;
  localparam int PTC_BIT_SECOND_RUN = 6;
  localparam int PTC_BIT_THIRD_RUN = 7;

  // ---------------------------------------------------------------
  // timing: one instruction cycle is four system clocks
  // ---------------------------------------------------------------
  localparam int PTC_CLOCKS_PER_INSTR = 4;
  localparam int PTC_DIV_WIDTH = 2;

endpackage : ptc_pkg

// ==== common/ptc_cnt_if.sv ====
// interface: main block to a period counter
`timescale 1ns/1ps
interface ptc_cnt_if #(parameter int WIDTH = 16);
  logic tick; // advance by one this cycle
  logic use_limit; // wrap at limit, else run over the full range
  logic [WIDTH-1:0] limit; // period match value
  logic load_low; // software write of the low byte
  logic load_high; // software write of the high byte
  logic [7:0] load_byte; // byte written by software
  logic [WIDTH-1:0] count; // present count
  logic wrap; // one-cycle pulse: count rolled over to zero

  modport ctl (output tick, use_limit, limit, load_low, load_high, load_byte,
               input count, wrap);
  modport cnt (input tick, use_limit, limit, load_low, load_high, load_byte,
               output count, wrap);
endinterface : ptc_cnt_if

// ==== hdl/ptc_edge_sync.sv ====
// module: pin synchroniser with rising-edge pulse
`timescale 1ns/1ps
module ptc_edge_sync
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // asynchronous pin
  input wire logic pin_in,
  // one-cycle pulse per rising edge of the pin
  output logic rise_out
);
  logic sync1_ff; // first stage, read only by the second stage
  logic sync2_ff; // second stage, safe to use
  logic last_ff; // previous synchronised level for edge detection

  // ---------------------------------------------------------------
  // synchroniser and edge detector
  // ---------------------------------------------------------------
  // the edge is taken between stage two and a third flop, so the
  // metastable first stage feeds nothing but the second
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      last_ff <= sync2_ff;
    end
  end

  assign rise_out = sync2_ff & ~last_ff;
endmodule : ptc_edge_sync

// ==== hdl/ptc_period_counter.sv ====
// module: period counter that wraps to zero at its limit
`timescale 1ns/1ps
module ptc_period_counter
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // control from the main block
  ptc_cnt_if.cnt cnt_if
);
  localparam int W = $bits(cnt_if.count);

  logic [W-1:0] count_ff; // present count
  logic wrap_ff; // rollover pulse
  logic at_limit; // count equals the wrap point

  // ---------------------------------------------------------------
  // wrap point
  // ---------------------------------------------------------------
  // without a limit the counter simply overflows from all ones
  assign at_limit = cnt_if.use_limit ? (count_ff == cnt_if.limit) : (&count_ff);

  // ---------------------------------------------------------------
  // count register
  // ---------------------------------------------------------------
  // a software byte write beats a tick in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      count_ff <= '0;
    end
    else if (cnt_if.load_low || cnt_if.load_high)
    begin
      if (cnt_if.load_low)
      begin
        count_ff[7:0] <= cnt_if.load_byte;
      end
      if (cnt_if.load_high && (W > 8))
      begin
        count_ff[W-1:W-8] <= cnt_if.load_byte;
      end
    end
    else if (cnt_if.tick)
    begin
      count_ff <= at_limit ? '0 : count_ff + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // rollover pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wrap_ff <= 1'b0;
    end
    else
    begin
      wrap_ff <= cnt_if.tick && at_limit && !(cnt_if.load_low || cnt_if.load_high);
    end
  end

  assign cnt_if.count = count_ff;
  assign cnt_if.wrap = wrap_ff;
endmodule : ptc_period_counter

// ==== hdl/ptc_timers.sv ====
// module: three period timers with flags and one interrupt
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module ptc_timers
  import ptc_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RD_DATA_OUT,
  // external clock pins
  input wire logic SHARED_TIMER_CLOCK_PIN_IN,
  input wire logic THIRD_TIMER_CLOCK_PIN_IN,
  // capture unit: take the third count into the period register
  input wire logic CAPTURE2_STROBE_IN,
  // time bases for the PWM and capture units
  output logic [7:0] FIRST_TIMER_COUNT_OUT,
  output logic [7:0] SECOND_TIMER_COUNT_OUT,
  output logic [15:0] THIRD_TIMER_COUNT_OUT,
  output logic FIRST_WRAP_OUT,
  output logic SECOND_WRAP_OUT,
  output logic THIRD_WRAP_OUT,
  // interrupt
  output logic IRQ_OUT
);
  import ptc_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0] control_ff; // mode and run bits
  logic [7:0] flags_ff; // sticky event flags
  logic [7:0] enables_ff; // interrupt enables
  logic [7:0] first_period_ff; // first_period_limit
  logic [7:0] second_period_ff; // second_period_limit
  logic [15:0] third_period_ff; // third period, or second capture register
  logic [7:0] first_count_ff; // first_timer_count
  logic [7:0] second_count_ff; // second_timer_count
  logic [PTC_DIV_WIDTH-1:0] div_ff; // instruction cycle divider
  logic instr_tick; // one pulse per instruction cycle
  logic shared_rise; // synchronised shared pin edge
  logic third_rise; // synchronised third pin edge
  logic first_tick; // first (or joined) timer advance
  logic second_tick; // second timer advance
  logic joined; // 16-bit joined mode
  logic dual_capture; // third period register used for capture
  logic first_hit; // first count at its wrap point
  logic second_hit; // second count at its wrap point
  logic joined_hit; // joined count at its wrap point
  logic first_wrap; // first (or joined) rollover this cycle
  logic second_wrap; // second rollover this cycle
  logic [7:0] nxt_flags; // next value of the flags
  logic [7:0] set_mask; // events raised this cycle
  logic [7:0] rd_mux; // read data before the register

  ptc_cnt_if #(.WIDTH(16)) third_if ();

  // write strobe decode shared by every register
  function automatic logic wr_hit(input logic [7:0] ofs);
    return WR_IN && (ADDR_IN == ofs);
  endfunction : wr_hit

  assign joined = control_ff[PTC_BIT_JOINED];
  assign dual_capture = control_ff[PTC_BIT_DUAL_CAPTURE];

  // ---------------------------------------------------------------
  // instruction cycle divider
  // ---------------------------------------------------------------
  // internal counting runs at a quarter of the system clock
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      div_ff <= '0;
    end
    else
    begin
      div_ff <= div_ff + 1'b1;
    end
  end

  assign instr_tick = (div_ff == PTC_DIV_WIDTH'(PTC_CLOCKS_PER_INSTR - 1));

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  ptc_edge_sync u_shared_sync (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .pin_in(SHARED_TIMER_CLOCK_PIN_IN),
    .rise_out(shared_rise)
  );

  ptc_edge_sync u_third_sync (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .pin_in(THIRD_TIMER_CLOCK_PIN_IN),
    .rise_out(third_rise)
  );

  // ---------------------------------------------------------------
  // tick selection
  // ---------------------------------------------------------------
  // joined mode is driven by the first timer's source and run bit
  assign first_tick = control_ff[PTC_BIT_FIRST_RUN] &&
                      (control_ff[PTC_BIT_FIRST_EXT] ? shared_rise : instr_tick);
  assign second_tick = !joined && control_ff[PTC_BIT_SECOND_RUN] &&
                       (control_ff[PTC_BIT_SECOND_EXT] ? shared_rise : instr_tick);

  // ---------------------------------------------------------------
  // wrap detection, first and second timers
  // ---------------------------------------------------------------
  assign first_hit = (first_count_ff == first_period_ff);
  assign second_hit = (second_count_ff == second_period_ff);
  assign joined_hit = ({second_count_ff, first_count_ff} ==
                       {second_period_ff, first_period_ff});
  assign first_wrap = first_tick && (joined ? joined_hit : first_hit) &&
                      !wr_hit(PTC_OFS_FIRST_COUNT);
  assign second_wrap = second_tick && second_hit && !wr_hit(PTC_OFS_SECOND_COUNT);

  // ---------------------------------------------------------------
  // first timer count (low byte when joined)
  // ---------------------------------------------------------------
  // software write wins over a tick in the same cycle
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      first_count_ff <= '0;
    end
    else if (wr_hit(PTC_OFS_FIRST_COUNT))
    begin
      first_count_ff <= WR_DATA_IN;
    end
    else if (first_tick)
    begin
      first_count_ff <= first_wrap ? 8'h00 : first_count_ff + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // second timer count (high byte when joined)
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      second_count_ff <= '0;
    end
    else if (wr_hit(PTC_OFS_SECOND_COUNT))
    begin
      second_count_ff <= WR_DATA_IN;
    end
    else if (joined && first_tick)
    begin
      // carry from the low byte, cleared on the joined rollover
      if (first_wrap)
      begin
        second_count_ff <= 8'h00;
      end
      else if (&first_count_ff)
      begin
        second_count_ff <= second_count_ff + 8'h01;
      end
    end
    else if (second_tick)
    begin
      second_count_ff <= second_wrap ? 8'h00 : second_count_ff + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // third timer
  // ---------------------------------------------------------------
  // in dual capture mode the period register no longer limits the count
  assign third_if.tick = control_ff[PTC_BIT_THIRD_RUN] &&
                         (control_ff[PTC_BIT_THIRD_EXT] ? third_rise : instr_tick);
  assign third_if.use_limit = !dual_capture;
  assign third_if.limit = third_period_ff;
  assign third_if.load_low = wr_hit(PTC_OFS_THIRD_LOW);
  assign third_if.load_high = wr_hit(PTC_OFS_THIRD_HIGH);
  assign third_if.load_byte = WR_DATA_IN;

  ptc_period_counter u_third (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .cnt_if(third_if)
  );

  // ---------------------------------------------------------------
  // period registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      first_period_ff <= PTC_RST_PERIOD;
      second_period_ff <= PTC_RST_PERIOD;
    end
    else
    begin
      if (wr_hit(PTC_OFS_FIRST_PERIOD))
      begin
        first_period_ff <= WR_DATA_IN;
      end
      if (wr_hit(PTC_OFS_SECOND_PERIOD))
      begin
        second_period_ff <= WR_DATA_IN;
      end
    end
  end

  // third period: a capture strobe in dual mode beats a software write
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      third_period_ff <= {PTC_RST_PERIOD, PTC_RST_PERIOD};
    end
    else if (dual_capture && CAPTURE2_STROBE_IN)
    begin
      third_period_ff <= third_if.count;
    end
    else
    begin
      if (wr_hit(PTC_OFS_THIRD_PER_LOW))
      begin
        third_period_ff[7:0] <= WR_DATA_IN;
      end
      if (wr_hit(PTC_OFS_THIRD_PER_HIGH))
      begin
        third_period_ff[15:8] <= WR_DATA_IN;
      end
    end
  end

  // ---------------------------------------------------------------
  // control and enable registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      control_ff <= PTC_RST_CONTROL;
      enables_ff <= PTC_RST_ENABLES;
    end
    else
    begin
      if (wr_hit(PTC_OFS_CONTROL))
      begin
        control_ff <= WR_DATA_IN;
      end
      if (wr_hit(PTC_OFS_EVENT_ENABLES))
      begin
        enables_ff <= WR_DATA_IN;
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky event flags, write one to clear, set wins
  // ---------------------------------------------------------------
  always_comb
  begin
    set_mask = 8'h00;
    set_mask[PTC_BIT_FIRST_FLAG] = first_wrap;
    set_mask[PTC_BIT_SECOND_FLAG] = second_wrap;
    set_mask[PTC_BIT_THIRD_FLAG] = third_if.wrap;
    nxt_flags = flags_ff;
    if (wr_hit(PTC_OFS_EVENT_FLAGS))
    begin
      nxt_flags = flags_ff & ~WR_DATA_IN;
    end
    nxt_flags = nxt_flags | set_mask;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      flags_ff <= PTC_RST_FLAGS;
    end
    else
    begin
      flags_ff <= nxt_flags;
    end
  end

  // ---------------------------------------------------------------
  // interrupt line
  // ---------------------------------------------------------------
  // registered from the next flags, so it changes in the same clock as the flags
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      IRQ_OUT <= 1'b0;
    end
    else
    begin
      IRQ_OUT <= |(nxt_flags & enables_ff);
    end
  end

  // ---------------------------------------------------------------
  // read mux and read data register
  // ---------------------------------------------------------------
  always_comb
  begin
    case (ADDR_IN)
      PTC_OFS_CONTROL: rd_mux = control_ff;
      PTC_OFS_FIRST_COUNT: rd_mux = first_count_ff;
      PTC_OFS_SECOND_COUNT: rd_mux = second_count_ff;
      PTC_OFS_THIRD_LOW: rd_mux = third_if.count[7:0];
      PTC_OFS_THIRD_HIGH: rd_mux = third_if.count[15:8];
      PTC_OFS_EVENT_FLAGS: rd_mux = flags_ff;
      PTC_OFS_EVENT_ENABLES: rd_mux = enables_ff;
      PTC_OFS_FIRST_PERIOD: rd_mux = first_period_ff;
      PTC_OFS_SECOND_PERIOD: rd_mux = second_period_ff;
      PTC_OFS_THIRD_PER_LOW: rd_mux = third_period_ff[7:0];
      PTC_OFS_THIRD_PER_HIGH: rd_mux = third_period_ff[15:8];
      default: rd_mux = PTC_RD_UNMAPPED;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      RD_DATA_OUT <= 8'h00;
    end
    else
    begin
      RD_DATA_OUT <= RD_IN ? rd_mux : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // time base outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      FIRST_WRAP_OUT <= 1'b0;
      SECOND_WRAP_OUT <= 1'b0;
    end
    else
    begin
      FIRST_WRAP_OUT <= first_wrap;
      SECOND_WRAP_OUT <= second_wrap;
    end
  end

  assign FIRST_TIMER_COUNT_OUT = first_count_ff;
  assign SECOND_TIMER_COUNT_OUT = second_count_ff;
  assign THIRD_TIMER_COUNT_OUT = third_if.count;
  assign THIRD_WRAP_OUT = third_if.wrap;
endmodule : ptc_timers

// ==== tb/ptc_timers_checker.sv ====
// checker: port timing relations of the period timers
`timescale 1ns/1ps
module ptc_timers_checker
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // register port and timer outputs
  input wire logic WR_IN,
  input wire logic [7:0] FIRST_TIMER_COUNT_OUT,
  input wire logic [7:0] SECOND_TIMER_COUNT_OUT,
  input wire logic [15:0] THIRD_TIMER_COUNT_OUT,
  input wire logic FIRST_WRAP_OUT,
  input wire logic SECOND_WRAP_OUT,
  input wire logic THIRD_WRAP_OUT,
  input wire logic IRQ_OUT
);
  // ---------------------------------------------------------------
  // sequences and properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  logic any_wrap; // some timer reported a rollover
  assign any_wrap = FIRST_WRAP_OUT | SECOND_WRAP_OUT | THIRD_WRAP_OUT;
  // a tick moved the first count, not a software write
  sequence s_first_tick;
    $changed(FIRST_TIMER_COUNT_OUT) && !$past(WR_IN);
  endsequence
  // the third count fell to zero by counting
  sequence s_third_zero;
    $past(THIRD_TIMER_COUNT_OUT) != 16'h0000 && THIRD_TIMER_COUNT_OUT == 16'h0000
      && !$past(WR_IN);
  endsequence
  property p_first_wrap;
    FIRST_WRAP_OUT |-> FIRST_TIMER_COUNT_OUT == 8'h00 || $past(WR_IN);
  endproperty
  a_first_wrap: assert property (p_first_wrap) else $error("first wrap, count not zero");
  property p_second_wrap;
    SECOND_WRAP_OUT |-> SECOND_TIMER_COUNT_OUT == 8'h00 || $past(WR_IN);
  endproperty
  a_second_wrap: assert property (p_second_wrap) else $error("second wrap, count not zero");
  property p_wrap_pulse;
    $rose(SECOND_WRAP_OUT) |=> !SECOND_WRAP_OUT;
  endproperty
  a_wrap_pulse: assert property (p_wrap_pulse) else $error("second wrap too long");
  property p_third_wrap;
    THIRD_WRAP_OUT |-> THIRD_TIMER_COUNT_OUT == 16'h0000 || $past(WR_IN);
  endproperty
  a_third_wrap: assert property (p_third_wrap) else $error("third wrap, count not zero");
  property p_third_zero;
    s_third_zero |-> ##[0:2] THIRD_WRAP_OUT;
  endproperty
  a_third_zero: assert property (p_third_zero) else $error("third rollover unreported");
  // ticks come no closer than one instruction cycle
  property p_tick_gap;
    s_first_tick |-> ##1 ($stable(FIRST_TIMER_COUNT_OUT) || $past(WR_IN)) [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("first count ticks too fast");
  property p_irq_rise;
    $rose(IRQ_OUT) |-> $past(WR_IN) || $past(WR_IN, 2) || any_wrap || $past(any_wrap);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
  // only software clears a sticky flag or an enable
  property p_irq_fall;
    $fell(IRQ_OUT) |-> $past(WR_IN) || $past(WR_IN, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
endmodule : ptc_timers_checker

bind ptc_timers ptc_timers_checker i_ptc_timers_checker (.CLK_IN, .RST_B_IN, .WR_IN,
  .FIRST_TIMER_COUNT_OUT, .SECOND_TIMER_COUNT_OUT, .THIRD_TIMER_COUNT_OUT,
  .FIRST_WRAP_OUT, .SECOND_WRAP_OUT, .THIRD_WRAP_OUT, .IRQ_OUT);

// ==== tb/ptc_pin_model.sv ====
// partner: pulse trains on the external timer clock pins
`timescale 1ns/1ps
module ptc_pin_model
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // train requests
  input wire logic shared_en_in,
  input wire logic third_en_in,
  // pins
  output logic shared_pin_out,
  output logic third_pin_out
);
  logic [2:0] phase_ff; // six-clock pulse period
  logic [1:0] act_ff; // requests taken only at a period boundary
  // three high, three low: no level shorter than the synchroniser needs
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      phase_ff <= 3'h0;
      act_ff <= 2'h0;
    end
    else
    begin
      phase_ff <= (phase_ff == 3'h5) ? 3'h0 : phase_ff + 3'h1;
      if (phase_ff == 3'h5)
        act_ff <= {third_en_in, shared_en_in};
    end
  end
  // pins rest low between trains
  assign shared_pin_out = act_ff[0] && phase_ff < 3'h3;
  assign third_pin_out = act_ff[1] && phase_ff < 3'h3;
endmodule : ptc_pin_model

// ==== tb/ptc_timers_tb_top.sv ====
// testbench: register table, timer rows and corner cases
`timescale 1ns/1ps
module ptc_timers_tb_top;
  import ptc_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] exp;} ptc_reg_row_t;
  typedef struct {logic [7:0] ctl; logic [7:0] pa; logic [15:0] per; int src; int sel;
    int clks;} ptc_tmr_row_t;
  logic clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, cap = 1'b0;
  logic sh_en = 1'b0, th_en = 1'b0;
  logic pin_sh, pin_th, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [7:0] rd_data, c1, c2;
  logic [15:0] c3;
  logic [2:0] wraps; // rollover pulses, third to first
  int n_errors = 0, cmp_count = 0, cyc = 0;
  // reset values, read-back, unmapped place, write-one-to-clear
  ptc_reg_row_t reg_rows[12] = '{
    '{1'b0, 8'h16, 8'h00, 8'h02}, '{1'b0, 8'h17, 8'h00, 8'h00},
    '{1'b0, 8'h10, 8'h00, 8'h00}, '{1'b0, 8'h18, 8'h00, 8'hFF},
    '{1'b0, 8'h1B, 8'h00, 8'hFF}, '{1'b0, 8'h11, 8'h00, 8'h00},
    '{1'b1, 8'h11, 8'hA5, 8'hA5}, '{1'b1, 8'h14, 8'hC3, 8'hC3},
    '{1'b1, 8'h1A, 8'h5A, 8'h5A}, '{1'b1, 8'h15, 8'h5A, 8'h00},
    '{1'b1, 8'h16, 8'h00, 8'h02}, '{1'b1, 8'h16, 8'h02, 8'h00}};
  // control, period place, period, source (0 int, 1 shared, 2 third), timer, clocks a tick
  ptc_tmr_row_t tmr_rows[7] = '{
    '{8'h20, 8'h18, 16'h0002, 0, 0, 4}, '{8'h40, 8'h19, 16'h0001, 0, 1, 4},
    '{8'h21, 8'h18, 16'h0001, 1, 0, 6}, '{8'h42, 8'h19, 16'h0002, 1, 1, 6},
    '{8'h28, 8'h18, 16'h0100, 0, 0, 4}, '{8'h80, 8'h1A, 16'h0003, 0, 2, 4},
    '{8'h84, 8'h1A, 16'h0001, 2, 2, 6}};
  ptc_timers i_ptc_timers (.CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr),
    .WR_DATA_IN(wdata), .WR_IN(wr_stb), .RD_IN(rd_stb), .RD_DATA_OUT(rd_data),
    .SHARED_TIMER_CLOCK_PIN_IN(pin_sh), .THIRD_TIMER_CLOCK_PIN_IN(pin_th),
    .CAPTURE2_STROBE_IN(cap), .FIRST_TIMER_COUNT_OUT(c1), .SECOND_TIMER_COUNT_OUT(c2),
    .THIRD_TIMER_COUNT_OUT(c3), .FIRST_WRAP_OUT(wraps[0]), .SECOND_WRAP_OUT(wraps[1]),
    .THIRD_WRAP_OUT(wraps[2]), .IRQ_OUT(irq));
  ptc_pin_model i_ptc_pin_model (.clk_in(clk), .rst_b_in(rst_b), .shared_en_in(sh_en),
    .third_en_in(th_en), .shared_pin_out(pin_sh), .third_pin_out(pin_th));
  always #20 clk = ~clk;
  // cycle count; the ceiling cuts a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      $display("MISMATCH t=%0t run too long", $time);
      close_out();
    end
  end
  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp);
    chk_val(16'(got), 16'(exp));
  endtask : chk_bit
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : bus_wr
  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk_val({8'h00, rd_data}, {8'h00, exp});
  endtask : bus_rd
  // bounded wait for one rollover pulse of timer s
  task automatic wait_wrap(input int s);
    repeat (3000)
    begin
      @(posedge clk);
      #1;
      if (wraps[s] === 1'b1)
        break;
    end
    chk_bit(wraps[s], 1'b1);
  endtask : wait_wrap
  // two rollovers: count, spacing, flag, interrupt, clearing
  task automatic run_row(input ptc_tmr_row_t r);
    int t0;
    logic [7:0] fl;
    fl = 8'h10 << r.sel;
    bus_wr(PTC_OFS_CONTROL, 8'h00);
    for (int i = 0; i < 4; i++)
      bus_wr(8'(8'h11 + i), 8'h00);
    bus_wr(r.pa, r.per[7:0]);
    bus_wr(8'(r.pa + 8'h01), r.per[15:8]);
    bus_wr(PTC_OFS_EVENT_ENABLES, fl);
    sh_en <= (r.src == 1);
    th_en <= (r.src == 2);
    bus_wr(PTC_OFS_CONTROL, r.ctl);
    wait_wrap(r.sel);
    t0 = cyc;
    chk_val(r.sel == 2 ? c3 : {8'h00, r.sel == 1 ? c2 : c1}, 16'h0000);
    wait_wrap(r.sel);
    chk_val(16'(cyc - t0), 16'((r.per + 1) * r.clks));
    bus_rd(PTC_OFS_EVENT_FLAGS, fl);
    chk_bit(irq, 1'b1);
    bus_wr(PTC_OFS_CONTROL, 8'h00);
    {th_en, sh_en} <= 2'b00;
    bus_wr(PTC_OFS_EVENT_FLAGS, fl);
    repeat (3) @(posedge clk);
    chk_bit(irq, 1'b0);
  endtask : run_row
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (reg_rows[i])
    begin
      if (reg_rows[i].wr)
        bus_wr(reg_rows[i].a, reg_rows[i].d);
      bus_rd(reg_rows[i].a, reg_rows[i].exp);
    end
    foreach (tmr_rows[i])
      run_row(tmr_rows[i]);
    // capture into the third period register, then no period limit
    bus_wr(PTC_OFS_CONTROL, 8'h10);
    bus_wr(PTC_OFS_THIRD_LOW, 8'h34);
    bus_wr(PTC_OFS_THIRD_HIGH, 8'h12);
    @(posedge clk);
    cap <= 1'b1;
    @(posedge clk);
    cap <= 1'b0;
    bus_rd(PTC_OFS_THIRD_PER_LOW, 8'h34);
    bus_rd(PTC_OFS_THIRD_PER_HIGH, 8'h12);
    bus_wr(PTC_OFS_THIRD_LOW, 8'h30);
    bus_wr(PTC_OFS_CONTROL, 8'h90);
    repeat (40) @(posedge clk);
    bus_wr(PTC_OFS_CONTROL, 8'h10);
    chk_bit(c3 > 16'h1234 && c3 < 16'h1240, 1'b1);
    // reset in mid-run with an interrupt pending
    bus_wr(PTC_OFS_EVENT_ENABLES, 8'h70);
    bus_wr(PTC_OFS_CONTROL, 8'hE0);
    repeat (20) @(posedge clk);
    chk_bit(irq, 1'b1);
    rst_b <= 1'b0;
    #1;
    chk_val(c3, 16'h0000);
    chk_bit(irq, 1'b0);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    bus_rd(PTC_OFS_EVENT_FLAGS, 8'h02);
    close_out();
  end
endmodule : ptc_timers_tb_top
